// ==== bdm_pkg.sv ====
// constants for the banked data memory map
package bdm_pkg;
  // address split
  localparam int BDM_ADDR_W     = 12;
  localparam int BDM_OFS_W      = 7;
  localparam int BDM_BANK_W     = 5;
  localparam int BDM_NUM_BANKS  = 32;
  localparam int BDM_BANK_BYTES = 128;
  localparam int BDM_DATA_W     = 8;
  // pointer high bits above the data address must be zero
  localparam int BDM_PTR_HI_USED = BDM_ADDR_W - 8;
  // in-bank regions
  localparam logic [6:0] BDM_CORE_FIRST = 7'h00;
  localparam logic [6:0] BDM_CORE_LAST  = 7'h0b;
  localparam int         BDM_CORE_NUM   = 12;
  localparam logic [6:0] BDM_SFR_FIRST  = 7'h0c;
  localparam logic [6:0] BDM_SFR_LAST   = 7'h1f;
  localparam logic [6:0] BDM_GPR_FIRST  = 7'h20;
  localparam logic [6:0] BDM_GPR_LAST   = 7'h6f;
  localparam int         BDM_GPR_BYTES  = 80;
  localparam logic [6:0] BDM_COM_FIRST  = 7'h70;
  localparam int         BDM_COM_BYTES  = 16;
  // core register offsets
  localparam logic [3:0] OFS_INDIRECT_DATA_PORT0        = 4'h0;
  localparam logic [3:0] OFS_INDIRECT_DATA_PORT1        = 4'h1;
  localparam logic [3:0] OFS_PROGRAM_COUNTER_LOW        = 4'h2;
  localparam logic [3:0] OFS_CORE_STATUS_FLAGS          = 4'h3;
  localparam logic [3:0] OFS_POINTER0_LOW               = 4'h4;
  localparam logic [3:0] OFS_POINTER0_HIGH              = 4'h5;
  localparam logic [3:0] OFS_POINTER1_LOW               = 4'h6;
  localparam logic [3:0] OFS_POINTER1_HIGH              = 4'h7;
  localparam logic [3:0] OFS_BANK_SELECTOR              = 4'h8;
  localparam logic [3:0] OFS_WORKING_ACCUMULATOR        = 4'h9;
  localparam logic [3:0] OFS_PROGRAM_COUNTER_HIGH_LATCH = 4'ha;
  localparam logic [3:0] OFS_INTERRUPT_CONTROL          = 4'hb;
  // reset values
  localparam logic [7:0] BDM_CORE_RESET = 8'h00;
  localparam logic [7:0] BDM_ZERO       = 8'h00;
  // region kinds of a resolved address
  typedef enum logic [2:0] {
    BDM_REG_CORE   = 3'b000,
    BDM_REG_INDIR  = 3'b001,
    BDM_REG_SFR    = 3'b010,
    BDM_REG_GPR    = 3'b011,
    BDM_REG_COM    = 3'b100,
    BDM_REG_UNIMPL = 3'b101
  } bdm_region_e;
endpackage

// ==== bdm_memory_map.sv ====
// banked data memory: address split, core registers, ram and bank select
// Functional notes
// - data memory is thirty-two banks of one hundred twenty-eight bytes each.
// - each bank maps 12 core, 20 special function, up to 80 ram bytes.
// - each bank also maps a sixteen-byte common ram region.
// - direct accesses use the bank last written into the bank selector.
// - reading any location without storage returns zero.
// - all memory reachable directly or through either of two pointer pairs.
// - twelve-bit address, top five bits bank, low seven bits offset.
// - core registers sit at offsets zero to eleven of every bank.
// - core register order: two ports, pc low, status, pointers, bank, acc, latch, irq.
`timescale 1ns/1ps
module bdm_memory_map
  import bdm_pkg::*;
#(
  parameter int GPR_BANKS = 4
) (
  // clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RESET_N,
  // access request from the core
  input  wire logic       REQ_VALID,
  input  wire logic       REQ_WRITE,
  input  wire logic [6:0] REQ_OFFSET,
  input  wire logic [7:0] REQ_WDATA,
  // read answer
  output logic      [7:0] RD_DATA,
  output logic            RD_VALID,
  // core register contents toward the datapath
  output logic      [4:0] BANK_NUMBER,
  output logic      [7:0] WORKING_ACC,
  output logic      [7:0] STATUS_FLAGS,
  output logic      [7:0] PC_LOW,
  output logic      [7:0] PC_HIGH_LATCH,
  output logic      [7:0] INT_CONTROL
);

  localparam int GPR_DEPTH = GPR_BANKS * BDM_GPR_BYTES;

  // region of a resolved twelve-bit address
  function automatic bdm_region_e region_of(input logic [11:0] a);
    logic [6:0] o;
    o = a[6:0];
    if (o <= BDM_CORE_LAST) begin
      if (o[3:0] == OFS_INDIRECT_DATA_PORT0 || o[3:0] == OFS_INDIRECT_DATA_PORT1) begin
        region_of = BDM_REG_INDIR;
      end else begin
        region_of = BDM_REG_CORE;
      end
    end else if (o <= BDM_SFR_LAST) begin
      region_of = BDM_REG_SFR;
    end else if (o <= BDM_GPR_LAST) begin
      if (int'(a[11:7]) < GPR_BANKS) begin
        region_of = BDM_REG_GPR;
      end else begin
        region_of = BDM_REG_UNIMPL;
      end
    end else begin
      region_of = BDM_REG_COM;
    end
  endfunction

  // flat ram index of a general purpose byte
  function automatic int gpr_index(input logic [11:0] a);
    gpr_index = int'(a[11:7]) * BDM_GPR_BYTES + int'(a[6:0] - BDM_GPR_FIRST);
  endfunction

  // storage
  logic [7:0] core_r   [BDM_CORE_NUM];
  logic [7:0] core_nxt [BDM_CORE_NUM];
  logic [7:0] gpr_r    [GPR_DEPTH];
  logic [7:0] gpr_nxt  [GPR_DEPTH];
  logic [7:0] com_r    [BDM_COM_BYTES];
  logic [7:0] com_nxt  [BDM_COM_BYTES];
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic       rd_valid_r;
  logic       rd_valid_nxt;

  // address resolution
  logic [11:0] direct_addr;
  logic [11:0] eff_addr;
  logic        eff_ok;
  bdm_region_e eff_region;
  logic [7:0]  ptr_hi;
  logic [7:0]  ptr_lo;
  logic [4:0]  bank_sel;

  // direct address from bank selector, indirect from a pointer pair
  always_comb begin
    bank_sel    = core_r[OFS_BANK_SELECTOR][4:0];
    direct_addr = {bank_sel, REQ_OFFSET};
    eff_addr    = direct_addr;
    eff_ok      = 1'b1;
    ptr_hi      = BDM_ZERO;
    ptr_lo      = BDM_ZERO;
    if (region_of(direct_addr) == BDM_REG_INDIR) begin
      if (REQ_OFFSET[3:0] == OFS_INDIRECT_DATA_PORT0) begin
        ptr_hi = core_r[OFS_POINTER0_HIGH];
        ptr_lo = core_r[OFS_POINTER0_LOW];
      end else begin
        ptr_hi = core_r[OFS_POINTER1_HIGH];
        ptr_lo = core_r[OFS_POINTER1_LOW];
      end
      eff_addr = {ptr_hi[BDM_PTR_HI_USED-1:0], ptr_lo};
      // pointer beyond the data space, or pointing at a port again
      eff_ok   = (ptr_hi[7:BDM_PTR_HI_USED] == '0) &&
                 (region_of({ptr_hi[BDM_PTR_HI_USED-1:0], ptr_lo}) != BDM_REG_INDIR);
    end
    eff_region = eff_ok ? region_of(eff_addr) : BDM_REG_UNIMPL;
  end

  // request strobes, low nibble for core and common storage, gpr position
  logic        wr_en;
  logic        rd_en;
  logic [3:0]  eff_low;
  int          gpr_idx;

  // decode shared by every storage group
  always_comb begin
    wr_en   = REQ_VALID && REQ_WRITE;
    rd_en   = REQ_VALID && !REQ_WRITE;
    eff_low = eff_addr[3:0];
    gpr_idx = 0;
    if (eff_region == BDM_REG_GPR) begin
      gpr_idx = gpr_index(eff_addr);
    end
  end

  // core register next values: one set, whichever bank is selected
  always_comb begin
    core_nxt = core_r;
    if (wr_en && eff_region == BDM_REG_CORE) begin
      if (eff_low == OFS_BANK_SELECTOR) begin
        core_nxt[eff_low] = {3'h0, REQ_WDATA[4:0]};
      end else begin
        core_nxt[eff_low] = REQ_WDATA;
      end
    end
  end

  // general purpose ram next values; other regions never reach it
  always_comb begin
    gpr_nxt = gpr_r;
    if (wr_en && eff_region == BDM_REG_GPR) begin
      gpr_nxt[gpr_idx] = REQ_WDATA;
    end
  end

  // common ram next values, shared by every bank
  always_comb begin
    com_nxt = com_r;
    if (wr_en && eff_region == BDM_REG_COM) begin
      com_nxt[eff_low] = REQ_WDATA;
    end
  end

  // read answer: one-cycle valid pulse, data held until the next read
  always_comb begin
    rd_valid_nxt = rd_en;
    rd_data_nxt  = rd_data_r;
    if (rd_en) begin
      case (eff_region)
        BDM_REG_CORE: rd_data_nxt = core_r[eff_low];
        BDM_REG_GPR:  rd_data_nxt = gpr_r[gpr_idx];
        BDM_REG_COM:  rd_data_nxt = com_r[eff_low];
        default:      rd_data_nxt = BDM_ZERO;
      endcase
    end
  end

  // core registers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < BDM_CORE_NUM; i++) begin
        core_r[i] <= BDM_CORE_RESET;
      end
    end else begin
      core_r <= core_nxt;
    end
  end

  // general purpose ram
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < GPR_DEPTH; i++) begin
        gpr_r[i] <= BDM_ZERO;
      end
    end else begin
      gpr_r <= gpr_nxt;
    end
  end

  // common ram
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < BDM_COM_BYTES; i++) begin
        com_r[i] <= BDM_ZERO;
      end
    end else begin
      com_r <= com_nxt;
    end
  end

  // read answer
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rd_data_r  <= BDM_ZERO;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // outputs
  assign RD_DATA       = rd_data_r;
  assign RD_VALID      = rd_valid_r;
  assign BANK_NUMBER   = core_r[OFS_BANK_SELECTOR][4:0];
  assign WORKING_ACC   = core_r[OFS_WORKING_ACCUMULATOR];
  assign STATUS_FLAGS  = core_r[OFS_CORE_STATUS_FLAGS];
  assign PC_LOW        = core_r[OFS_PROGRAM_COUNTER_LOW];
  assign PC_HIGH_LATCH = core_r[OFS_PROGRAM_COUNTER_HIGH_LATCH];
  assign INT_CONTROL   = core_r[OFS_INTERRUPT_CONTROL];

endmodule // bdm_memory_map

// ==== bdm_asserts.sv ====
// port assertions for the banked data memory map
`timescale 1ns/1ps
module bdm_asserts (
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       RESET_N,
  // request and answers
  input wire logic       REQ_VALID,
  input wire logic       REQ_WRITE,
  input wire logic [6:0] REQ_OFFSET,
  input wire logic [7:0] REQ_WDATA,
  input wire logic [7:0] RD_DATA,
  input wire logic       RD_VALID,
  input wire logic [4:0] BANK_NUMBER,
  input wire logic [7:0] WORKING_ACC
);
  default clocking @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // read and write requests taken at an edge
  logic rd_q;
  logic wr_q;
  logic special_function_register;
  logic ind;
  assign rd_q = REQ_VALID && !REQ_WRITE;
  assign wr_q = REQ_VALID && REQ_WRITE;
  assign special_function_register = REQ_OFFSET >= 7'h0c && REQ_OFFSET <= 7'h1f;
  // offsets 0x00 and 0x01 go through a pointer and may reach any core register except the two ports
  assign ind = REQ_OFFSET <= 7'h01;
  AST_RD_PULSE: assert property (rd_q |=> RD_VALID) else $error("no answer");
  AST_RD_CAUSE: assert property (RD_VALID |-> $past(rd_q)) else $error("stray answer");
  AST_BANK_SET: assert property (wr_q && REQ_OFFSET == 7'h08 |=>
    BANK_NUMBER == 5'($past(REQ_WDATA))) else $error("bank not set");
  AST_BANK_KEEP: assert property (!(wr_q && (REQ_OFFSET == 7'h08 || ind)) |=>
    $stable(BANK_NUMBER)) else $error("bank moved");
  AST_ACC_SET: assert property (wr_q && REQ_OFFSET == 7'h09 |=>
    WORKING_ACC == $past(REQ_WDATA)) else $error("acc not set");
  AST_SFR_READ: assert property (rd_q && special_function_register |=> RD_DATA == 8'h00) else $error("sfr data");
  AST_DROP: assert property (wr_q && special_function_register |=>
    $stable(WORKING_ACC) && $stable(BANK_NUMBER)) else $error("write leaked");
  AST_ACC_READ: assert property (rd_q && REQ_OFFSET == 7'h09 |=>
    RD_DATA == WORKING_ACC) else $error("acc read");
  AST_BANK_READ: assert property (rd_q && REQ_OFFSET == 7'h08 |=>
    RD_DATA == {3'h0, BANK_NUMBER}) else $error("bank read");
endmodule // bdm_asserts
bind bdm_memory_map bdm_asserts u_asserts (.REF_CLK(REF_CLK), .RESET_N(RESET_N),
  .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_OFFSET(REQ_OFFSET),
  .REQ_WDATA(REQ_WDATA), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
  .BANK_NUMBER(BANK_NUMBER), .WORKING_ACC(WORKING_ACC));

// ==== bdm_core_model.sv ====
// core-side access driver for the banked data memory map
`timescale 1ns/1ps
module bdm_core_model (
  // clock
  input  wire logic       clk,
  // request toward the map
  output logic            req_valid,
  output logic            req_write,
  output logic      [6:0] req_offset,
  output logic      [7:0] req_wdata,
  // read answer
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid
);
  // one access a cycle from a falling edge; bank changes go through writes
  task automatic acc(input logic w, input logic [6:0] o, input logic [7:0] d,
                     output logic [7:0] q, output logic v);
    req_valid = 1'b1;
    req_write = w;
    req_offset = o;
    req_wdata = d;
    @(posedge clk);
    @(negedge clk);
    q = rd_data;
    v = rd_valid;
  endtask
  // drop the request, scramble stale write data
  task automatic idle();
    req_valid = 1'b0;
    req_wdata = ~req_wdata;
  endtask
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_offset = 7'h00;
    req_wdata = 8'h00;
  end
endmodule // bdm_core_model

// ==== tb.sv ====
// self-checking bench for the banked data memory map
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic v, w, rv;
  logic [6:0] o;
  logic [7:0] d, rd, acc, st, program_counter_low, pch, intc;
  logic [4:0] bank;
  int errors = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  bdm_memory_map #(.GPR_BANKS(2)) dut (.REF_CLK(clk), .RESET_N(rst_n), .REQ_VALID(v),
    .REQ_WRITE(w), .REQ_OFFSET(o), .REQ_WDATA(d), .RD_DATA(rd), .RD_VALID(rv),
    .BANK_NUMBER(bank), .WORKING_ACC(acc), .STATUS_FLAGS(st), .PC_LOW(program_counter_low),
    .PC_HIGH_LATCH(pch), .INT_CONTROL(intc));
  bdm_core_model core (.clk(clk), .req_valid(v), .req_write(w), .req_offset(o),
    .req_wdata(d), .rd_data(rd), .rd_valid(rv));
  // compare and count
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] x);
    logic [7:0] t;
    logic tv;
    core.acc(1'b1, a, x, t, tv);
  endtask
  // read with answer pulse check
  task automatic rc(input string n, input logic [6:0] a, input logic [7:0] e);
    logic [7:0] t;
    logic tv;
    core.acc(1'b0, a, 8'h00, t, tv);
    chk(n, 8'h01, {7'h00, tv});
    chk(n, e, t);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  // back-to-back access sequence
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    for (int b = 0; b < 2; b++) begin
      wr(7'h08, 8'(b));
      wr(7'h20, 8'ha0 + 8'(b));
    end
    wr(7'h08, 8'h00);
    rc("gpr0", 7'h20, 8'ha0);
    wr(7'h08, 8'hff);
    rc("bank", 7'h08, 8'h1f);
    wr(7'h20, 8'h55);
    rc("nogpr", 7'h20, 8'h00);
    wr(7'h0c, 8'h66);
    rc("sfr", 7'h0c, 8'h00);
    wr(7'h70, 8'h3c);
    wr(7'h09, 8'h5a);
    wr(7'h08, 8'h01);
    rc("common", 7'h70, 8'h3c);
    rc("acc", 7'h09, 8'h5a);
    wr(7'h04, 8'h20);
    wr(7'h06, 8'ha0);
    rc("ptr0", 7'h00, 8'ha0);
    wr(7'h01, 8'h77);
    rc("ptr1", 7'h20, 8'h77);
    wr(7'h05, 8'h10);
    rc("ptrhigh", 7'h00, 8'h00);
    wr(7'h07, 8'h00);
    wr(7'h06, 8'h01);
    wr(7'h01, 8'h99);
    rc("ptrloop", 7'h01, 8'h00);
    rc("acc2", 7'h09, 8'h5a);
    wr(7'h02, 8'h12);
    wr(7'h0a, 8'h1a);
    wr(7'h0b, 8'h1b);
    wr(7'h03, 8'h13);
    core.idle();
    chk("pcl", 8'h12, program_counter_low);
    chk("latch", 8'h1a, pch);
    chk("intc", 8'h1b, intc);
    chk("status", 8'h13, st);
    // reset again in mid-run: storage and outputs clear
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("rstacc", 8'h00, acc);
    chk("rstbank", 8'h00, {3'h0, bank});
    chk("rststatus", 8'h00, st);
    chk("rstpcl", 8'h00, program_counter_low);
    chk("rstlatch", 8'h00, pch);
    chk("rstintc", 8'h00, intc);
    chk("rstdata", 8'h00, rd);
    chk("rstvalid", 8'h00, {7'h00, rv});
    rc("rstgpr", 7'h20, 8'h00);
    rc("rstcom", 7'h70, 8'h00);
    finish_test();
  end
endmodule // tb
